/* dv/dtec_pin_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Pin-side partner: event source and capture inputs.
// ----------------------------------------------------------------
module dtec_pin_model (
    input  wire logic clk,              // System clock.
    output wire logic event_input_pin,  // External event pin.
    output wire logic capture_pin_0,    // First capture pin.
    output wire logic capture_pin_1     // Second capture pin.
);
    logic [2:0] lvl;  // Pin levels, bit 0 event, bits 1 and 2 capture.

    assign {capture_pin_1, capture_pin_0, event_input_pin} = lvl;

    initial begin
        lvl = 3'h0;
    end

    // Each level is held for two clocks, well above one cycle, so no edge is lost.
    task automatic pulse(input int which);
        @(posedge clk);
        lvl[which] <= 1'b1;
        repeat (2) @(posedge clk);
        lvl[which] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule // dtec_pin_model

`default_nettype wire

/* dv/tb_dual_timer_event_counter.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_dual_timer_event_counter;
    import dtec_pkg::*;

    // ----------------------------------------------------------------
    // Signals and bookkeeping.
    // ----------------------------------------------------------------
    logic          clk;              // System clock.
    logic          rst;              // Reset, active high.
    dtec_avs_req_s avs_req;          // Bus request.
    logic          avs_waitrequest;  // Bus wait.
    logic [31:0]   avs_readdata;     // Bus read data.
    logic          irq;              // Interrupt.
    wire logic     ev_pin;           // Event pin.
    wire logic     first_capture_enable;             // First capture pin.
    wire logic     second_capture_enable;             // Second capture pin.
    int            errors;           // Mismatch count.
    int            checks_done;      // Comparison count.
    int            cyc;              // Clock edges since start.
    int            last_rise;        // Edge of the latest interrupt rise.
    int            gap;              // Edges between the last two rises.
    int            rises;            // Number of interrupt rises.
    logic          irq_q;            // Interrupt one edge ago.
    logic [31:0]   rd;               // Scratch read data.

    dtec_timer_top u_dtec_timer_top (.clk(clk), .rst(rst), .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .irq(irq), .event_input_pin(ev_pin), .capture_pin_0(first_capture_enable),
        .capture_pin_1(second_capture_enable));
    dtec_pin_model u_dtec_pin_model (.clk(clk), .event_input_pin(ev_pin), .capture_pin_0(first_capture_enable), .capture_pin_1(second_capture_enable));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Measures the spacing of interrupt rises in clock edges.
    always @(posedge clk) begin
        cyc   <= cyc + 1;
        irq_q <= irq;
        if (irq === 1'b1 && irq_q === 1'b0) begin
            gap       <= cyc - last_rise;
            last_rise <= cyc;
            rises     <= rises + 1;
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus access held until waitrequest is sampled low.
    // No cycle limit here: the watchdog alone ends a wait that never completes.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_req <= '{read: !wr, write: wr, address: a, byteenable: 4'hf, writedata: {24'h0, d}};
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_req <= '0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    // Waits for three interrupt rises, clearing the flag after each; checks the last spacing.
    task automatic measure(input int bitn, input int exp_gap);
        int r0;
        wr(OFS_STATUS, 8'h0f);
        wr(OFS_MASK, 8'h01 << bitn);
        repeat (3) begin
            r0 = rises;
            while (rises == r0) begin
                @(posedge clk);
            end
            wr(OFS_STATUS, 8'h01 << bitn);
        end
        check("match interval", exp_gap, gap);
    endtask

    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic sc_reset_values();
        bus(1'b0, OFS_FIRST_MODE, 8'h0, rd);
        check("first mode", 32'h0, rd);
        bus(1'b0, OFS_STATUS, 8'h0, rd);
        check("status", 32'h0, rd);
        wr(OFS_FIRST, 8'h55);
        bus(1'b0, OFS_FIRST, 8'h0, rd);
        check("count after compare write", 32'h0, rd);
        bus(1'b0, 6'h3c, 8'h0, rd);
        check("unmapped", 32'h0, rd);
        check("irq idle", 32'h0, {31'h0, irq});
    endtask

    // Every first divide and every second divide with a fixed compare value.
    task automatic sc_dividers();
        int dv1 [7] = '{2, 4, 8, 32, 128, 512, 2048};
        int dv2 [3] = '{1, 2, 8};
        wr(OFS_FIRST, 8'h03);
        wr(OFS_SECOND, 8'h07);
        for (int c = 0; c < 7; c++) begin
            wr(OFS_FIRST_MODE, 8'h80 | c[7:0]);
            measure(0, 4 * dv1[c]);
        end
        wr(OFS_FIRST_MODE, 8'h00);
        for (int c = 0; c < 3; c++) begin
            wr(OFS_SECOND_MODE, 8'h80 | c[7:0]);
            measure(1, 8 * dv2[c]);
        end
        wr(OFS_SECOND_MODE, 8'h00);
    endtask

    // Chained interval, then a full sixteen-bit capture with the count stopped past 255.
    task automatic sc_chained();
        logic [31:0] hi;  // Upper count byte read before the capture.
        logic [31:0] lo;  // Lower count byte read before the capture.
        wr(OFS_FIRST, 8'h00);
        wr(OFS_SECOND, 8'h01);
        wr(OFS_SECOND_MODE, 8'ha3);
        wr(OFS_FIRST_MODE, 8'h80);
        measure(0, 2 * 257);
        wr(OFS_FIRST, 8'hff);
        wr(OFS_SECOND, 8'hff);
        repeat (600) @(posedge clk);
        wr(OFS_FIRST_MODE, 8'h10);
        bus(1'b0, OFS_SECOND, 8'h0, hi);
        bus(1'b0, OFS_FIRST, 8'h0, lo);
        check("chained count high", 32'h1, hi);
        u_dtec_pin_model.pulse(1);
        repeat (4) @(posedge clk);
        bus(1'b0, OFS_SECOND_CAP, 8'h0, rd);
        check("chained capture high", hi, rd);
        bus(1'b0, OFS_FIRST_CAP, 8'h0, rd);
        check("chained capture low", lo, rd);
    endtask

    task automatic sc_events();
        wr(OFS_PORT_SEL, 8'h08);
        wr(OFS_FIRST, 8'h02);
        wr(OFS_FIRST_MODE, 8'h97);
        wr(OFS_SECOND_MODE, 8'h93);
        repeat (2) u_dtec_pin_model.pulse(0);
        repeat (4) @(posedge clk);
        bus(1'b0, OFS_FIRST, 8'h0, rd);
        check("event count", 32'h2, rd);
        u_dtec_pin_model.pulse(1);
        u_dtec_pin_model.pulse(2);
        repeat (4) @(posedge clk);
        bus(1'b0, OFS_FIRST_CAP, 8'h0, rd);
        check("first capture", 32'h2, rd);
        bus(1'b0, OFS_SECOND, 8'h0, rd);
        check("second count", 32'h0, rd);
        u_dtec_pin_model.pulse(0);
        repeat (4) @(posedge clk);
        bus(1'b0, OFS_STATUS, 8'h0, rd);
        check("status after match", 32'hd, rd);
        bus(1'b0, OFS_FIRST, 8'h0, rd);
        check("count after match", 32'h0, rd);
        check("irq masked", 32'h0, {31'h0, irq});
        wr(OFS_MASK, 8'h01);
        repeat (2) @(posedge clk);
        check("irq unmasked", 32'h1, {31'h0, irq});
        wr(OFS_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b0, OFS_STATUS, 8'h0, rd);
        check("status after clear", 32'hc, rd);
    endtask

    // ----------------------------------------------------------------
    // Closing and main sequence.
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Longest expected run is near 36000 edges; the limit leaves headroom.
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        avs_req = '0;
        errors = 0;
        checks_done = 0;
        cyc = 0;
        last_rise = 0;
        gap = 0;
        rises = 0;
        irq_q = 1'b0;
        do_reset();
        sc_reset_values();
        sc_dividers();
        do_reset();
        sc_chained();
        do_reset();
        sc_events();
        print_verdict();
    end
endmodule // tb_dual_timer_event_counter

`default_nettype wire

/* verilog/dtec_pkg.sv */
`default_nettype none

package dtec_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets on the Avalon-MM slave.
    // ----------------------------------------------------------------
    localparam logic [5:0] OFS_FIRST       = 6'h00;  // First count read, compare write.
    localparam logic [5:0] OFS_SECOND      = 6'h04;  // Second count read, compare write.
    localparam logic [5:0] OFS_FIRST_MODE  = 6'h08;  // First mode register.
    localparam logic [5:0] OFS_SECOND_MODE = 6'h0c;  // Second mode register.
    localparam logic [5:0] OFS_PORT_SEL    = 6'h10;  // Port select register.
    localparam logic [5:0] OFS_STATUS      = 6'h14;  // Sticky event flags, write one to clear.
    localparam logic [5:0] OFS_MASK        = 6'h18;  // Interrupt mask, same layout as status.
    localparam logic [5:0] OFS_FIRST_CAP   = 6'h1c;  // First capture data.
    localparam logic [5:0] OFS_SECOND_CAP  = 6'h20;  // Second capture data.

    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int FM_CLK_LSB  = 0;  // First clock select, three bits.
    localparam int FM_CAP_BIT  = 4;  // First capture enable.
    localparam int FM_RUN_BIT  = 7;  // First timer run.
    localparam int SM_CLK_LSB  = 0;  // Second clock select, two bits.
    localparam int SM_CAP_BIT  = 4;  // Second capture enable.
    localparam int SM_CHN_BIT  = 5;  // Chain enable.
    localparam int SM_PWE_BIT  = 6;  // Pulse width enable, stored only.
    localparam int SM_RUN_BIT  = 7;  // Second timer run.
    localparam int PS_EVT_BIT  = 3;  // Routes the event pin to the first timer.
    localparam int PS_PLS_BIT  = 4;  // Pulse pin select, stored only.
    localparam int ST_M0_BIT   = 0;  // First match flag.
    localparam int ST_M1_BIT   = 1;  // Second match flag.
    localparam int ST_C0_BIT   = 2;  // First capture flag.
    localparam int ST_C1_BIT   = 3;  // Second capture flag.

    // ----------------------------------------------------------------
    // Reset values and select codes.
    // ----------------------------------------------------------------
    localparam logic [7:0] DATA_RST    = 8'hff;  // Compare data is undefined to software.
    localparam logic [7:0] MODE_RST    = 8'h00;  // Timers stopped, plain 8-bit mode.
    localparam logic [3:0] MASK_RST    = 4'h0;   // All interrupts masked.
    localparam logic [2:0] SEL_EVENT   = 3'h7;   // First clock select for event counting.
    localparam logic [1:0] SEL_CHAIN   = 2'h3;   // Second clock select for chaining.

    // Avalon-MM request from the master.
    typedef struct packed {
        logic        read;        // Read request.
        logic        write;       // Write request.
        logic [5:0]  address;     // Byte address.
        logic [3:0]  byteenable;  // Byte lanes.
        logic [31:0] writedata;   // Write data.
    } dtec_avs_req_s;

    // Whole state of the block.
    typedef struct packed {
        logic        waitrequest;  // Avalon wait.
        logic [31:0] readdata;     // Avalon read data.
        logic        irq;          // Interrupt level.
        logic [10:0] pre;          // Free running prescaler.
        logic [7:0]  first_cnt;    // First count.
        logic [7:0]  second_cnt;   // Second count.
        logic [7:0]  first_cmp;    // First compare data.
        logic [7:0]  second_cmp;   // Second compare data.
        logic [7:0]  first_mode;   // First mode register.
        logic [7:0]  second_mode;  // Second mode register.
        logic [7:0]  psel;         // Port select register.
        logic [7:0]  first_cap;    // First capture data.
        logic [7:0]  second_cap;   // Second capture data.
        logic [3:0]  status;       // Sticky flags.
        logic [3:0]  mask;         // Interrupt mask.
        logic [1:0]  ev_sync;      // Event pin synchroniser.
        logic        ev_prev;      // Registered synchronised event level.
        logic [1:0]  c0_sync;      // First capture pin synchroniser.
        logic        c0_prev;      // Registered first capture level.
        logic [1:0]  c1_sync;      // Second capture pin synchroniser.
        logic        c1_prev;      // Registered second capture level.
    } dtec_state_s;

endpackage

`default_nettype wire

/* verilog/dtec_timer_top.sv */
`timescale 1ns/1ns
`default_nettype none

module dtec_timer_top
    import dtec_pkg::*;
(
    input  wire logic          clk,              // System clock, 20 MHz.
    input  wire logic          rst,              // Asynchronous reset, active high.
    input  wire dtec_avs_req_s avs_req,          // Avalon-MM request.
    output var  logic          avs_waitrequest,  // Avalon-MM wait.
    output var  logic [31:0]   avs_readdata,     // Avalon-MM read data.
    output var  logic          irq,              // Interrupt level.
    input  wire logic          event_input_pin,  // External event pin.
    input  wire logic          capture_pin_0,    // First capture input.
    input  wire logic          capture_pin_1     // Second capture input.
);

    // ----------------------------------------------------------------
    // State and helper terms.
    // ----------------------------------------------------------------
    dtec_state_s state_ff;    // Registered state.
    dtec_state_s nxt_state;   // Next state.
    logic        bus_req;     // Read or write pending.
    logic        bus_acc;     // Access completes at this edge.
    logic        ev_edge;     // One pulse per routed event rising edge.
    logic        c0_edge;     // First capture edge.
    logic        c1_edge;     // Second capture edge.
    logic        chained;     // 16-bit mode.
    logic [2:0]  first_sel;   // First clock select.
    logic [1:0]  second_sel;  // Second clock select.
    logic        first_tick;  // First count enable pulse.
    logic        second_tick; // Second count enable pulse.

    assign bus_req    = avs_req.read | avs_req.write;
    assign bus_acc    = bus_req & ~state_ff.waitrequest;
    assign first_sel  = state_ff.first_mode[FM_CLK_LSB +: 3];
    assign second_sel = state_ff.second_mode[SM_CLK_LSB +: 2];
    assign chained    = state_ff.second_mode[SM_CHN_BIT] & (second_sel == SEL_CHAIN);

    // Only the second synchroniser stage and its delayed copy are compared.
    assign ev_edge = state_ff.ev_sync[1] & ~state_ff.ev_prev & state_ff.psel[PS_EVT_BIT];
    assign c0_edge = state_ff.c0_sync[1] & ~state_ff.c0_prev;
    assign c1_edge = state_ff.c1_sync[1] & ~state_ff.c1_prev;

    // ----------------------------------------------------------------
    // Count enables from the shared prescaler.
    // ----------------------------------------------------------------
    // A divide by 2^k fires when the low k prescaler bits are all ones.
    always_comb begin
        case (first_sel)
            3'h0: first_tick = state_ff.pre[0];
            3'h1: first_tick = &state_ff.pre[1:0];
            3'h2: first_tick = &state_ff.pre[2:0];
            3'h3: first_tick = &state_ff.pre[4:0];
            3'h4: first_tick = &state_ff.pre[6:0];
            3'h5: first_tick = &state_ff.pre[8:0];
            3'h6: first_tick = &state_ff.pre[10:0];
            default: first_tick = ev_edge;
        endcase
        first_tick = first_tick & state_ff.first_mode[FM_RUN_BIT];
    end

    // The second timer has no event input; code 11 only serves chaining.
    always_comb begin
        case (second_sel)
            2'h0: second_tick = 1'b1;
            2'h1: second_tick = state_ff.pre[0];
            2'h2: second_tick = &state_ff.pre[2:0];
            default: second_tick = 1'b0;
        endcase
        second_tick = second_tick & state_ff.second_mode[SM_RUN_BIT] & ~chained;
    end

    // ----------------------------------------------------------------
    // Next state.
    // ----------------------------------------------------------------
    always_comb begin
        logic [3:0]  set_bits;  // Events raised this cycle.
        logic [3:0]  clr_bits;  // Bits software clears this cycle.
        logic [15:0] wide;      // Chained count.
        set_bits  = 4'h0;
        clr_bits  = 4'h0;
        wide      = {state_ff.second_cnt, state_ff.first_cnt};
        nxt_state = state_ff;
        nxt_state.pre     = state_ff.pre + 11'h001;
        nxt_state.ev_sync = {state_ff.ev_sync[0], event_input_pin};
        nxt_state.ev_prev = state_ff.ev_sync[1];
        nxt_state.c0_sync = {state_ff.c0_sync[0], capture_pin_0};
        nxt_state.c0_prev = state_ff.c0_sync[1];
        nxt_state.c1_sync = {state_ff.c1_sync[0], capture_pin_1};
        nxt_state.c1_prev = state_ff.c1_sync[1];

        // Counting. A match on a tick clears the count and raises the flag
        // together, so the interval covers zero through the data value.
        if (chained) begin
            if (first_tick) begin
                if (wide == {state_ff.second_cmp, state_ff.first_cmp}) begin
                    wide = 16'h0000;
                    set_bits[ST_M0_BIT] = 1'b1;
                end else begin
                    wide = wide + 16'h0001;
                end
            end
            nxt_state.first_cnt  = wide[7:0];
            nxt_state.second_cnt = wide[15:8];
        end else begin
            if (first_tick) begin
                if (state_ff.first_cnt == state_ff.first_cmp) begin
                    nxt_state.first_cnt = 8'h00;
                    set_bits[ST_M0_BIT] = 1'b1;
                end else begin
                    nxt_state.first_cnt = state_ff.first_cnt + 8'h01;
                end
            end
            if (second_tick) begin
                if (state_ff.second_cnt == state_ff.second_cmp) begin
                    nxt_state.second_cnt = 8'h00;
                    set_bits[ST_M1_BIT]  = 1'b1;
                end else begin
                    nxt_state.second_cnt = state_ff.second_cnt + 8'h01;
                end
            end
        end

        // Capture copies the count as it stood before this edge's tick.
        // In chained mode the first input captures the full sixteen bits.
        if (c0_edge && state_ff.first_mode[FM_CAP_BIT]) begin
            nxt_state.first_cap = state_ff.first_cnt;
            if (chained) begin
                nxt_state.second_cap = state_ff.second_cnt;
            end
            set_bits[ST_C0_BIT] = 1'b1;
        end
        if (c1_edge && state_ff.second_mode[SM_CAP_BIT] && !chained) begin
            nxt_state.second_cap = state_ff.second_cnt;
            set_bits[ST_C1_BIT]  = 1'b1;
        end

        // Avalon slave: one wait cycle, then the access completes.
        nxt_state.waitrequest = 1'b1;
        nxt_state.readdata    = 32'h0000_0000;
        if (bus_req && state_ff.waitrequest) begin
            nxt_state.waitrequest = 1'b0;
            case (avs_req.address)  // Unmapped addresses read zero.
                OFS_FIRST:       nxt_state.readdata[7:0] = state_ff.first_cnt;
                OFS_SECOND:      nxt_state.readdata[7:0] = state_ff.second_cnt;
                OFS_FIRST_MODE:  nxt_state.readdata[7:0] = state_ff.first_mode;
                OFS_SECOND_MODE: nxt_state.readdata[7:0] = state_ff.second_mode;
                OFS_PORT_SEL:    nxt_state.readdata[7:0] = state_ff.psel;
                OFS_STATUS:      nxt_state.readdata[3:0] = state_ff.status;
                OFS_MASK:        nxt_state.readdata[3:0] = state_ff.mask;
                OFS_FIRST_CAP:   nxt_state.readdata[7:0] = state_ff.first_cap;
                OFS_SECOND_CAP:  nxt_state.readdata[7:0] = state_ff.second_cap;
                default:         nxt_state.readdata = 32'h0000_0000;
            endcase
        end
        // Writes take effect at the edge where waitrequest is low; unmapped
        // addresses and writes without lane 0 are ignored.
        if (bus_acc && avs_req.write && avs_req.byteenable[0]) begin
            case (avs_req.address)
                OFS_FIRST:       nxt_state.first_cmp   = avs_req.writedata[7:0];
                OFS_SECOND:      nxt_state.second_cmp  = avs_req.writedata[7:0];
                OFS_FIRST_MODE:  nxt_state.first_mode  = avs_req.writedata[7:0];
                OFS_SECOND_MODE: nxt_state.second_mode = avs_req.writedata[7:0];
                OFS_PORT_SEL:    nxt_state.psel        = avs_req.writedata[7:0];
                OFS_STATUS:      clr_bits              = avs_req.writedata[3:0];
                OFS_MASK:        nxt_state.mask        = avs_req.writedata[3:0];
                default:         clr_bits              = 4'h0;
            endcase
        end

        // A flag raised in the same cycle as its clear stays set.
        nxt_state.status = (state_ff.status & ~clr_bits) | set_bits;
        nxt_state.irq    = |(nxt_state.status & nxt_state.mask);
    end

    // ----------------------------------------------------------------
    // State register.
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff             <= '0;
            state_ff.waitrequest <= 1'b1;
            state_ff.first_cmp   <= DATA_RST;
            state_ff.second_cmp  <= DATA_RST;
            state_ff.first_mode  <= MODE_RST;
            state_ff.second_mode <= MODE_RST;
            state_ff.psel        <= MODE_RST;
            state_ff.mask        <= MASK_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign avs_waitrequest = state_ff.waitrequest;
    assign avs_readdata    = state_ff.readdata;
    assign irq             = state_ff.irq;

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_FIRST_WRAP: assert property (
        (first_tick && !chained && state_ff.first_cnt == state_ff.first_cmp)
        |=> (state_ff.first_cnt == 8'h00) && state_ff.status[ST_M0_BIT])
        else $error("First timer did not wrap on match.");

    AST_SECOND_WRAP: assert property (
        (second_tick && state_ff.second_cnt == state_ff.second_cmp)
        |=> (state_ff.second_cnt == 8'h00) && state_ff.status[ST_M1_BIT])
        else $error("Second timer did not wrap on match.");

    // A mode write may land in either of the two following cycles, so each step re-checks the select.
    AST_FIRST_DIV2: assert property (
        (first_tick && first_sel == 3'h0)
        |=> (!first_tick || first_sel != 3'h0)
        ##1 (first_tick || first_sel != 3'h0 || !state_ff.first_mode[FM_RUN_BIT]))
        else $error("Divide by two tick spacing wrong.");

    AST_SECOND_DIV1: assert property (
        (second_sel == 2'h0 && state_ff.second_mode[SM_RUN_BIT] && !chained) |-> second_tick)
        else $error("Undivided second tick missing.");

    AST_EVENT_COUNT: assert property (
        (ev_edge && first_sel == SEL_EVENT && state_ff.first_mode[FM_RUN_BIT] && !chained
         && state_ff.first_cnt != state_ff.first_cmp)
        |=> state_ff.first_cnt == $past(state_ff.first_cnt) + 8'h01)
        else $error("Event edge not counted.");

    AST_EDGE_PULSE: assert property (
        ev_edge |=> !ev_edge)
        else $error("Event pulse longer than one cycle.");

    AST_CAPTURE: assert property (
        (c0_edge && state_ff.first_mode[FM_CAP_BIT])
        |=> state_ff.first_cap == $past(state_ff.first_cnt) && state_ff.status[ST_C0_BIT])
        else $error("Capture did not copy the count.");

    AST_STICKY: assert property (
        (state_ff.status[ST_M0_BIT] && !(bus_acc && avs_req.write && avs_req.address == OFS_STATUS))
        |=> state_ff.status[ST_M0_BIT])
        else $error("Match flag dropped without a clear.");

    AST_READ_COUNT: assert property (
        (avs_req.read && state_ff.waitrequest && avs_req.address == OFS_FIRST)
        |=> !avs_waitrequest && avs_readdata[7:0] == $past(state_ff.first_cnt))
        else $error("Count read returned wrong value.");

    AST_CHAIN_WRAP: assert property (
        (chained && first_tick
         && {state_ff.second_cnt, state_ff.first_cnt} == {state_ff.second_cmp, state_ff.first_cmp})
        |=> {state_ff.second_cnt, state_ff.first_cnt} == 16'h0000 && state_ff.status[ST_M0_BIT])
        else $error("Chained timer did not wrap on match.");

endmodule // dtec_timer_top

`default_nettype wire
